//--- common/timing_strobe_pkg.sv
// constants shared by the timing strobe block and its mark qualifier
package timing_strobe_pkg;
	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int MARK_MIN_NS = 150;
	localparam int MARK_MIN_CYC = (MARK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_MIN_US = 20;
	localparam int RST_MIN_CYC = (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [31:0] FREQ_STEP_MAX = 32'h33333333; // 50 MHz at 250 MHz
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] TP_PERIOD_OFS = 8'h04;
	localparam logic [7:0] TP_WIDTH_OFS = 8'h08;
	localparam logic [7:0] FREQ_STEP_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
	localparam logic [7:0] MARK_A_TIME_OFS = 8'h1C;
	localparam logic [7:0] MARK_B_TIME_OFS = 8'h20;
	localparam logic [7:0] TIME_NOW_OFS = 8'h24;
	// ************************************************************
	// control fields
	// ************************************************************
	localparam int CTRL_MARK_A_POL = 0;
	localparam int CTRL_MARK_B_POL = 1;
	localparam int CTRL_SERIAL3_EN = 2;
	localparam int CTRL_CAN_PORT_ONE_EN = 3;
	localparam int CTRL_TP_POL = 4;
	localparam int CTRL_FREQ_POL = 5;
	localparam int CTRL_TP_EN = 6;
	localparam int CTRL_FREQ_EN = 7;
	localparam int CTRL_W = 8;
	localparam logic [7:0] CTRL_RST = 8'hC0;
	localparam logic [31:0] TP_PERIOD_RST = 32'h0EE6B280;
	localparam logic [31:0] TP_WIDTH_RST = 32'h017D7840;
	localparam logic [31:0] FREQ_STEP_RST = 32'h00000000;
	// ************************************************************
	// interrupt and status fields
	// ************************************************************
	localparam int IRQ_MARK_A = 0;
	localparam int IRQ_MARK_B = 1;
	localparam int IRQ_TP_EDGE = 2;
	localparam int IRQ_POS_CHG = 3;
	localparam int IRQ_W = 4;
	localparam int ST_POS_VALID = 0;
	localparam int ST_TP_ACTIVE = 1;
	localparam int ST_EXT_RST = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : timing_strobe_pkg

//--- design/mark_qualify.sv
// pin synchroniser with polarity select and minimum pulse width check
`timescale 1ns/1ns
module mark_qualify
	import timing_strobe_pkg::*;
#(
	parameter int MIN_CYC = MARK_MIN_CYC
) (
	input wire logic aclk,
	input wire logic rst_n,
	input wire logic pin_in,
	input wire logic active_high,
	input wire logic enable,
	output logic qual_pulse,
	output logic qual_level
);
	localparam int CW = $clog2(MIN_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(MIN_CYC - 1);
	localparam logic [CW-1:0] TOP = CW'(MIN_CYC);

	logic sync1_r;
	logic sync2_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic qual_pulse_r;
	logic qual_level_r;

	// ************************************************************
	// width qualification
	// ************************************************************
	// sync1_r feeds sync2_r only; everything else looks at sync2_r
	wire active = enable && (sync2_r == active_high);
	wire at_last = (cnt_r == LAST);
	assign cnt_nxt = !active ? '0 : (cnt_r == TOP) ? cnt_r : cnt_r + 1'b1;

	// two flops before any logic reads the pin
	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	// one pulse per qualified mark, level held while it lasts
	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			cnt_r <= '0;
			qual_pulse_r <= 1'b0;
			qual_level_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			qual_pulse_r <= active && at_last;
			qual_level_r <= active && (cnt_r >= LAST);
		end
	end

	assign qual_pulse = qual_pulse_r;
	assign qual_level = qual_level_r;

	property p_mark_no_glitch;
		@(posedge aclk) disable iff (!rst_n)
		qual_pulse_r |-> $past(cnt_r) == LAST && qual_level_r;
	endproperty
	a_mark_no_glitch: assert property (p_mark_no_glitch) else $error("mark pulse without full width");

	property p_mark_single;
		@(posedge aclk) disable iff (!rst_n)
		qual_pulse_r |=> !qual_pulse_r;
	endproperty
	a_mark_single: assert property (p_mark_single) else $error("mark fired twice for one pulse");

	property p_mark_disabled;
		@(posedge aclk) disable iff (!rst_n)
		!enable |=> !qual_pulse_r && !qual_level_r;
	endproperty
	a_mark_disabled: assert property (p_mark_disabled) else $error("mark seen while input disabled");
endmodule : mark_qualify

//--- design/timing_strobe_io.sv
// timing strobe unit: marks, time pulse, position valid, frequency output
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
// What this block does
// - marks longer than 150 ns raise records
// - mark polarity selectable, default active low
// - mark B pin becomes CAN one transmit
// - time pulse leading edge on satellite epoch
// - time pulse polarity, period, width programmable
// - position valid follows solution availability
// - reset low over 20 us resets block
// - frequency output zero to 50 MHz
// - frequency pin becomes CAN one receive
module timing_strobe_io
	import timing_strobe_pkg::*;
#(
	parameter int RST_CYC = RST_MIN_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_reset_n,
	input wire logic mark_input_a_in,
	output logic mark_input_a_out,
	output logic mark_input_a_oe,
	input wire logic mark_input_b_in,
	output logic mark_input_b_out,
	output logic mark_input_b_oe,
	input wire logic variable_freq_in,
	output logic variable_freq_out,
	output logic variable_freq_oe,
	input wire logic serial_three_txd,
	input wire logic can_one_txd,
	output logic can_one_rxd,
	input wire logic sat_time_epoch,
	input wire logic solution_valid,
	output logic time_pulse_out,
	output logic position_valid_out,
	output logic mark_a_position_record,
	output logic [31:0] mark_a_time_record,
	output logic mark_b_position_record,
	output logic [31:0] mark_b_time_record,
	output logic card_reset_out,
	output logic irq
);
	// ************************************************************
	// helpers
	// ************************************************************
	// byte-lane merge for partial writes
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	// true when the address names a register of this block
	function automatic logic is_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= TIME_NOW_OFS);
	endfunction : is_mapped

	logic ext_rst_lvl;
	logic [CTRL_W-1:0] ctrl_r;
	logic [31:0] tp_period_r;
	logic [31:0] tp_width_r;
	logic [31:0] freq_step_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [31:0] time_now_r;
	logic [31:0] tp_cnt_r;
	logic [31:0] tp_cnt_nxt;
	logic [31:0] nco_r;
	logic tp_out_r;
	logic tp_act_r;
	logic pos_valid_r;
	logic freq_out_r;
	logic can_rx1_r;
	logic can_rx2_r;
	logic [31:0] mark_a_time_r;
	logic [31:0] mark_b_time_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic mark_a_stb;
	logic mark_b_stb;

	// ************************************************************
	// reset qualification and marks
	// ************************************************************
	// external reset counts only after a low stretch of RST_CYC cycles
	mark_qualify #(.MIN_CYC(RST_CYC)) u_ext_rst (
		.aclk(aclk),
		.rst_n(aresetn),
		.pin_in(ext_reset_n),
		.active_high(1'b0),
		.enable(1'b1),
		.qual_pulse(),
		.qual_level(ext_rst_lvl)
	);

	wire blk_rst_n = aresetn && !ext_rst_lvl;
	wire serial3_en = ctrl_r[CTRL_SERIAL3_EN];
	wire can_port_one_en = ctrl_r[CTRL_CAN_PORT_ONE_EN];

	// mark A qualifier, silenced while the pin carries serial data
	mark_qualify #(.MIN_CYC(MARK_MIN_CYC)) u_mark_a (
		.aclk(aclk),
		.rst_n(blk_rst_n),
		.pin_in(mark_input_a_in),
		.active_high(ctrl_r[CTRL_MARK_A_POL]),
		.enable(!serial3_en),
		.qual_pulse(mark_a_stb),
		.qual_level()
	);

	// mark B qualifier, silenced while the pin carries CAN transmit
	mark_qualify #(.MIN_CYC(MARK_MIN_CYC)) u_mark_b (
		.aclk(aclk),
		.rst_n(blk_rst_n),
		.pin_in(mark_input_b_in),
		.active_high(ctrl_r[CTRL_MARK_B_POL]),
		.enable(!can_port_one_en),
		.qual_pulse(mark_b_stb),
		.qual_level()
	);

	// ************************************************************
	// register bus decode
	// ************************************************************
	// address and data are taken together; one write outstanding
	wire wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
	wire rd_take = s_axi_arvalid && !rvalid_r;
	wire [7:0] wa = s_axi_awaddr;
	wire wr_ctrl = wr_take && wa == CTRL_OFS;
	wire wr_per = wr_take && wa == TP_PERIOD_OFS;
	wire wr_wid = wr_take && wa == TP_WIDTH_OFS;
	wire wr_step = wr_take && wa == FREQ_STEP_OFS;
	wire wr_istat = wr_take && wa == IRQ_STAT_OFS && s_axi_wstrb[0];
	wire wr_imask = wr_take && wa == IRQ_MASK_OFS && s_axi_wstrb[0];
	wire [31:0] ctrl_wide = merge_bytes({24'h0, ctrl_r}, s_axi_wdata, s_axi_wstrb);
	wire [IRQ_W-1:0] w1c = wr_istat ? s_axi_wdata[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] irq_ev = {pos_valid_r != solution_valid, tp_act_r == 1'b0 && tp_cnt_nxt == 32'h0
		&& ctrl_r[CTRL_TP_EN], mark_b_stb, mark_a_stb};
	wire [2:0] status_v = {ext_rst_lvl, tp_act_r, pos_valid_r};
	wire [31:0] step_clamp = (freq_step_r > FREQ_STEP_MAX) ? FREQ_STEP_MAX : freq_step_r;

	assign s_axi_awready = wr_take;
	assign s_axi_wready = wr_take;
	assign s_axi_arready = rd_take;

	// read mux, reserved bits read zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		unique case (s_axi_araddr)
			CTRL_OFS: rd_mux = {24'h0, ctrl_r};
			TP_PERIOD_OFS: rd_mux = tp_period_r;
			TP_WIDTH_OFS: rd_mux = tp_width_r;
			FREQ_STEP_OFS: rd_mux = freq_step_r;
			STATUS_OFS: rd_mux = {29'h0, status_v};
			IRQ_STAT_OFS: rd_mux = {28'h0, irq_stat_r};
			IRQ_MASK_OFS: rd_mux = {28'h0, irq_mask_r};
			MARK_A_TIME_OFS: rd_mux = mark_a_time_r;
			MARK_B_TIME_OFS: rd_mux = mark_b_time_r;
			TIME_NOW_OFS: rd_mux = time_now_r;
			default: rd_mux = 32'h0;
		endcase
	end

	// ************************************************************
	// register bus responses
	// ************************************************************
	// bus channels reset by aresetn only, so a pin reset never breaks a transfer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0;
		end else begin
			if (wr_take) begin
				bvalid_r <= 1'b1;
				bresp_r <= is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
			if (rd_take) begin
				rvalid_r <= 1'b1;
				rresp_r <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				rdata_r <= rd_mux;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// ************************************************************
	// configuration registers
	// ************************************************************
	// factory defaults: marks active low, pulse and frequency active low
	always_ff @(posedge aclk) begin
		if (!blk_rst_n) begin
			ctrl_r <= CTRL_RST;
			tp_period_r <= TP_PERIOD_RST;
			tp_width_r <= TP_WIDTH_RST;
			freq_step_r <= FREQ_STEP_RST;
			irq_mask_r <= '0;
		end else begin
			if (wr_ctrl) ctrl_r <= ctrl_wide[CTRL_W-1:0];
			if (wr_per) tp_period_r <= merge_bytes(tp_period_r, s_axi_wdata, s_axi_wstrb);
			if (wr_wid) tp_width_r <= merge_bytes(tp_width_r, s_axi_wdata, s_axi_wstrb);
			if (wr_step) freq_step_r <= merge_bytes(freq_step_r, s_axi_wdata, s_axi_wstrb);
			if (wr_imask) irq_mask_r <= s_axi_wdata[IRQ_W-1:0];
		end
	end

	// sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!blk_rst_n) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~w1c) | irq_ev;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// ************************************************************
	// time base and mark records
	// ************************************************************
	// free time count, captured on each qualified mark
	always_ff @(posedge aclk) begin
		if (!blk_rst_n) begin
			time_now_r <= 32'h0;
			mark_a_time_r <= 32'h0;
			mark_b_time_r <= 32'h0;
		end else begin
			time_now_r <= time_now_r + 32'h1;
			if (mark_a_stb) mark_a_time_r <= time_now_r;
			if (mark_b_stb) mark_b_time_r <= time_now_r;
		end
	end

	assign mark_a_position_record = mark_a_stb;
	assign mark_b_position_record = mark_b_stb;
	assign mark_a_time_record = mark_a_time_r;
	assign mark_b_time_record = mark_b_time_r;

	// ************************************************************
	// time pulse
	// ************************************************************
	// epoch restarts the period so the leading edge lands on it
	assign tp_cnt_nxt = sat_time_epoch ? 32'h0 :
		(tp_cnt_r + 32'h1 >= tp_period_r) ? 32'h0 : tp_cnt_r + 32'h1;
	wire tp_act_nxt = ctrl_r[CTRL_TP_EN] && (tp_cnt_nxt < tp_width_r);

	always_ff @(posedge aclk) begin
		if (!blk_rst_n) begin
			tp_cnt_r <= 32'h0;
			tp_act_r <= 1'b0;
			tp_out_r <= 1'b1;
		end else begin
			tp_cnt_r <= tp_cnt_nxt;
			tp_act_r <= tp_act_nxt;
			tp_out_r <= ctrl_r[CTRL_TP_POL] ? tp_act_nxt : !tp_act_nxt;
		end
	end

	assign time_pulse_out = tp_out_r;

	// ************************************************************
	// frequency output, shared pins, position valid
	// ************************************************************
	// phase accumulator; msb gives the square wave, zero step holds still
	wire [31:0] nco_nxt = nco_r + step_clamp;
	wire freq_act = ctrl_r[CTRL_FREQ_EN] && nco_nxt[31];

	always_ff @(posedge aclk) begin
		if (!blk_rst_n) begin
			nco_r <= 32'h0;
			freq_out_r <= 1'b1;
			pos_valid_r <= 1'b0;
			can_rx1_r <= 1'b1;
			can_rx2_r <= 1'b1;
		end else begin
			nco_r <= nco_nxt;
			freq_out_r <= ctrl_r[CTRL_FREQ_POL] ? freq_act : !freq_act;
			pos_valid_r <= solution_valid;
			can_rx1_r <= variable_freq_in;
			can_rx2_r <= can_rx1_r;
		end
	end

	// pin ownership follows the port enables
	assign mark_input_a_out = serial3_en ? serial_three_txd : 1'b0;
	assign mark_input_a_oe = serial3_en;
	assign mark_input_b_out = can_port_one_en ? can_one_txd : 1'b0;
	assign mark_input_b_oe = can_port_one_en;
	assign variable_freq_out = freq_out_r;
	assign variable_freq_oe = !can_port_one_en;
	assign can_one_rxd = can_port_one_en ? can_rx2_r : 1'b1;
	assign position_valid_out = pos_valid_r;
	assign card_reset_out = ext_rst_lvl;

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_epoch;
		sat_time_epoch && ctrl_r[CTRL_TP_EN] && tp_width_r != 32'h0;
	endsequence
	property p_tp_lead;
		@(posedge aclk) disable iff (!blk_rst_n)
		blk_rst_n ##0 s_epoch ##0 $stable(ctrl_r) |=> tp_act_r && tp_cnt_r == 32'h0;
	endproperty
	a_tp_lead: assert property (p_tp_lead) else $error("time pulse not started on epoch");

	property p_tp_pol;
		@(posedge aclk) disable iff (!blk_rst_n)
		$stable(ctrl_r) |-> time_pulse_out == (ctrl_r[CTRL_TP_POL] ? tp_act_r : !tp_act_r);
	endproperty
	a_tp_pol: assert property (p_tp_pol) else $error("time pulse polarity wrong");

	property p_pos_valid;
		@(posedge aclk) disable iff (!blk_rst_n)
		// the release edge itself still clears the flop, so only check from a running cycle
		blk_rst_n |=> position_valid_out == $past(solution_valid);
	endproperty
	a_pos_valid: assert property (p_pos_valid) else $error("position valid lags wrong");

	property p_ext_rst;
		@(posedge aclk) disable iff (!aresetn)
		ext_rst_lvl |=> ctrl_r == CTRL_RST && irq_stat_r == '0;
	endproperty
	a_ext_rst: assert property (p_ext_rst) else $error("pin reset did not clear block");

	property p_freq_step;
		@(posedge aclk) disable iff (!blk_rst_n)
		!wr_step |=> nco_r == $past(nco_r) + $past(step_clamp) && step_clamp <= FREQ_STEP_MAX;
	endproperty
	a_freq_step: assert property (p_freq_step) else $error("frequency accumulator step wrong");

	property p_can_pins;
		@(posedge aclk) disable iff (!blk_rst_n)
		can_port_one_en |-> !variable_freq_oe && mark_input_b_oe && mark_input_b_out == can_one_txd;
	endproperty
	a_can_pins: assert property (p_can_pins) else $error("CAN pin sharing wrong");

	property p_serial_pin;
		@(posedge aclk) disable iff (!blk_rst_n)
		serial3_en |-> mark_input_a_oe && mark_input_a_out == serial_three_txd && (!mark_a_stb || !$past(serial3_en));
	endproperty
	a_serial_pin: assert property (p_serial_pin) else $error("serial pin sharing wrong");

	property p_mark_irq;
		@(posedge aclk) disable iff (!blk_rst_n)
		mark_a_stb |=> irq_stat_r[IRQ_MARK_A] && mark_a_time_r == $past(time_now_r);
	endproperty
	a_mark_irq: assert property (p_mark_irq) else $error("mark A not recorded");
endmodule : timing_strobe_io

//--- dv/host_stub.sv
// host side model: reset pin, mark pins and the shared receive line
`timescale 1ns/1ns
module host_stub (
	input wire logic aclk,
	input wire logic a_oe,
	input wire logic a_out,
	input wire logic b_oe,
	input wire logic b_out,
	input wire logic f_oe,
	input wire logic f_out,
	output logic a_pin,
	output logic b_pin,
	output logic f_pin,
	output logic ext_reset_n
);
	logic a_lvl = 1'b1;
	logic b_lvl = 1'b1;
	logic f_lvl = 1'b1;
	// device drive wins; an undriven pin follows the host level set by hold
	assign a_pin = a_oe ? a_out : a_lvl;
	assign b_pin = b_oe ? b_out : b_lvl;
	assign f_pin = f_oe ? f_out : f_lvl;
	// reset held low at power-up so the supply settles before boot
	initial begin
		ext_reset_n = 1'b0;
		repeat (15) @(posedge aclk);
		ext_reset_n <= 1'b1;
	end
	// set one host level, called just after a clock edge
	task automatic hold(input int sel, input logic lvl);
		case (sel)
			0: a_lvl <= lvl;
			1: b_lvl <= lvl;
			2: f_lvl <= lvl;
			default: ext_reset_n <= lvl;
		endcase
	endtask : hold
	// level held for exactly cyc cycles, then returned
	task automatic pulse(input int sel, input logic lvl, input int cyc);
		hold(sel, lvl);
		repeat (cyc) @(posedge aclk);
		hold(sel, !lvl);
		@(posedge aclk);
	endtask : pulse
endmodule : host_stub

//--- dv/testbench.sv
// self-checking bench for the timing strobe block
`timescale 1ns/1ns
module testbench
	import timing_strobe_pkg::*;
;
	localparam int RST_SMALL = 8;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, mark_a_time_record, mark_b_time_record, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_reset_n;
	logic mark_input_a_in, mark_input_a_out, mark_input_a_oe, mark_input_b_in, mark_input_b_out;
	logic mark_input_b_oe, variable_freq_in, variable_freq_out, variable_freq_oe, serial_three_txd;
	logic can_one_txd, can_one_rxd, sat_time_epoch, solution_valid, time_pulse_out, position_valid_out;
	logic mark_a_position_record, mark_b_position_record, card_reset_out, irq;
	int error_cnt = 0;
	int samples_checked = 0;
	int rec_a = 0;
	int rec_b = 0;
	int cr_cyc = 0;
	// ************************************************************
	// clock, instances, monitors
	// ************************************************************
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	timing_strobe_io #(.RST_CYC(RST_SMALL)) dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ext_reset_n, .mark_input_a_in, .mark_input_a_out, .mark_input_a_oe, .mark_input_b_in,
		.mark_input_b_out, .mark_input_b_oe, .variable_freq_in, .variable_freq_out, .variable_freq_oe,
		.serial_three_txd, .can_one_txd, .can_one_rxd, .sat_time_epoch, .solution_valid, .time_pulse_out,
		.position_valid_out, .mark_a_position_record, .mark_a_time_record, .mark_b_position_record,
		.mark_b_time_record, .card_reset_out, .irq);
	host_stub u_host (.aclk, .a_oe(mark_input_a_oe), .a_out(mark_input_a_out), .b_oe(mark_input_b_oe),
		.b_out(mark_input_b_out), .f_oe(variable_freq_oe), .f_out(variable_freq_out),
		.a_pin(mark_input_a_in), .b_pin(mark_input_b_in), .f_pin(variable_freq_in), .ext_reset_n);
	// tally record pulses and reset-held cycles
	always @(posedge aclk) begin
		if (mark_a_position_record === 1'b1) rec_a++;
		if (mark_b_position_record === 1'b1) rec_b++;
		if (card_reset_out === 1'b1) cr_cyc++;
	end
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one bus transfer; the first wait ends on the ready-sampling edge, the second on bvalid/rvalid, bready/rready stay high
	// waits are open ended; a hung slave is caught by the watchdog
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_arvalid <= !wr;
		do begin
			@(posedge aclk);
		end while ((wr ? (s_axi_awready && s_axi_wready) : s_axi_arready) !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge aclk);
		end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
		rd = s_axi_rdata;
		rsp = wr ? s_axi_bresp : s_axi_rresp;
	endtask : axi
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		axi(1'b0, a, 32'h00000000);
		check(rd, e);
	endtask : rd_chk
	task automatic count_level(input logic lvl, input int cyc, output int n);
		n = 0;
		repeat (cyc) begin
			@(posedge aclk);
			if (time_pulse_out === lvl) n++;
		end
	endtask : count_level
	// edges seen on the frequency pin over cyc cycles
	task automatic toggles(input int cyc, output int n);
		logic prev;
		n = 0;
		prev = variable_freq_in;
		repeat (cyc) begin
			@(posedge aclk);
			if (variable_freq_in !== prev) n++;
			prev = variable_freq_in;
		end
	endtask : toggles
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_regs();
		rd_chk(CTRL_OFS, {24'h000000, CTRL_RST});
		rd_chk(TP_PERIOD_OFS, TP_PERIOD_RST);
		rd_chk(TP_WIDTH_OFS, TP_WIDTH_RST);
		rd_chk(8'h40, 32'h00000000);
		check({30'h0, rsp}, {30'h0, RESP_SLVERR});
	endtask : t_regs
	task automatic t_posval();
		solution_valid <= 1'b1;
		repeat (2) @(posedge aclk);
		check(position_valid_out, 1'b1);
		rd_chk(STATUS_OFS, 32'h00000003);
		solution_valid <= 1'b0;
		repeat (2) @(posedge aclk);
		check(position_valid_out, 1'b0);
	endtask : t_posval
	task automatic t_tpulse();
		int n;
		axi(1'b1, TP_PERIOD_OFS, 32'h00000014);
		axi(1'b1, TP_WIDTH_OFS, 32'h00000005);
		sat_time_epoch <= 1'b1;
		@(posedge aclk);
		sat_time_epoch <= 1'b0;
		repeat (3) @(posedge aclk);
		check(time_pulse_out, 1'b0);
		count_level(1'b0, 40, n);
		check(n, 10);
		axi(1'b1, CTRL_OFS, 32'h000000D0);
		count_level(1'b1, 40, n);
		check(n, 10);
		axi(1'b1, CTRL_OFS, 32'h000000C0);
	endtask : t_tpulse
	task automatic t_freq();
		int n;
		logic lvl;
		axi(1'b1, FREQ_STEP_OFS, 32'hFFFFFFFF);
		repeat (5) @(posedge aclk);
		check(variable_freq_oe, 1'b1);
		toggles(100, n);
		check(n >= 38 && n <= 42, 1'b1);
		// zero step freezes the accumulator, so the pin stands at whatever level it held
		axi(1'b1, FREQ_STEP_OFS, 32'h00000000);
		repeat (5) @(posedge aclk);
		toggles(40, n);
		check(n, 0);
		// with the accumulator still, the polarity bit alone flips the pin
		lvl = variable_freq_in;
		axi(1'b1, CTRL_OFS, 32'h000000E0);
		repeat (3) @(posedge aclk);
		check(variable_freq_in ^ lvl, 1'b1);
		axi(1'b1, CTRL_OFS, 32'h000000C0);
	endtask : t_freq
	task automatic t_mark();
		int a0, b0;
		a0 = rec_a;
		b0 = rec_b;
		u_host.pulse(0, 1'b0, 30);
		repeat (10) @(posedge aclk);
		check(rec_a - a0, 0);
		u_host.pulse(0, 1'b0, 40);
		u_host.pulse(1, 1'b0, 40);
		repeat (5) @(posedge aclk);
		check(rec_a - a0, 1);
		check(rec_b - b0, 1);
		// mark B started 41 cycles after mark A, so its time stamp trails by that much
		check(mark_b_time_record - mark_a_time_record, 32'h00000029);
		rd_chk(IRQ_STAT_OFS, 32'h0000000F);
		check(irq, 1'b0);
		axi(1'b1, IRQ_MASK_OFS, 32'h00000001);
		check(irq, 1'b1);
		axi(1'b1, IRQ_STAT_OFS, 32'h00000001);
		check(irq, 1'b0);
		// active high: a low pulse must not count, the return to high must
		axi(1'b1, CTRL_OFS, 32'h000000C1);
		repeat (50) @(posedge aclk);
		a0 = rec_a;
		u_host.pulse(0, 1'b0, 60);
		check(rec_a - a0, 0);
		repeat (50) @(posedge aclk);
		check(rec_a - a0, 1);
		axi(1'b1, CTRL_OFS, 32'h000000C0);
	endtask : t_mark
	task automatic t_share();
		int a0, b0;
		a0 = rec_a;
		b0 = rec_b;
		axi(1'b1, CTRL_OFS, 32'h000000CC);
		check(mark_input_a_oe, 1'b1);
		check(mark_input_b_oe, 1'b1);
		check(variable_freq_oe, 1'b0);
		u_host.hold(2, 1'b0);
		serial_three_txd <= 1'b0;
		can_one_txd <= 1'b0;
		repeat (45) @(posedge aclk);
		check(mark_input_a_in, 1'b0);
		check(mark_input_b_in, 1'b0);
		check(can_one_rxd, 1'b0);
		check(rec_a - a0, 0);
		check(rec_b - b0, 0);
		serial_three_txd <= 1'b1;
		can_one_txd <= 1'b1;
		u_host.hold(2, 1'b1);
		@(posedge aclk);
		axi(1'b1, CTRL_OFS, 32'h000000C0);
		repeat (5) @(posedge aclk);
		check(can_one_rxd, 1'b1);
	endtask : t_share
	task automatic t_ext();
		int c0;
		c0 = cr_cyc;
		u_host.pulse(3, 1'b0, RST_SMALL / 2);
		repeat (10) @(posedge aclk);
		check(cr_cyc - c0, 0);
		axi(1'b1, CTRL_OFS, 32'h000000C8);
		u_host.pulse(3, 1'b0, RST_SMALL + 10);
		repeat (10) @(posedge aclk);
		check(cr_cyc > c0, 1'b1);
		check(card_reset_out, 1'b0);
		rd_chk(CTRL_OFS, {24'h000000, CTRL_RST});
	endtask : t_ext
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	// main sequence: inputs valued at time zero, then reset for ten cycles
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sat_time_epoch, solution_valid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_bready, s_axi_rready, serial_three_txd, can_one_txd} = 4'hF;
		s_axi_wstrb = 4'hF;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (30) @(posedge aclk);
		t_regs();
		t_posval();
		t_tpulse();
		t_freq();
		t_mark();
		t_share();
		t_ext();
		stop_test();
	end
	// watchdog: the sequence needs under a thousand cycles
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
endmodule : testbench
